// ==== hdl/fdi_timing.v ====
// Floating-point decode classification, issue control and unit timing
// Contract
// - Common FP ops take the short decode path and only rare or line-straddling ones the slower vector path.
// - A short-decodable op that straddles a cache line is vector decoded with extra cycles.
// - Short-decodable FP ops are accepted only by the first decoder slot.
// - An FP op pairs with a short op in the same cycle only when the FP op comes first.
// - SIMD registers alias the FP stack, so a state clear is needed before FP use.
// - The switch cost after a state clear is charged when the next FP op arrives.
// - Integer and FP multipliers are separate and may run at the same time.
// - FP arithmetic and compare with an integer memory operand cost nothing extra.
// - FP multiply completes much sooner than FP divide.
// - FP load and FP store take two cycles each, five for a dependent pair with one release cycle between them.
// - One integer load and one store are taken each cycle.
// - The FP unit is not pipelined; a new op starts only after the last completes.
// - Common FP ops complete in two cycles.
// - FP ops with a memory source have the same throughput as register forms.
`timescale 1ns/100ps
`include "fdi_timing_regs.vh"

module fdi_timing #(
   parameter [`FDI_CNT_W-1:0] FP_DIV_CYC = `FDI_FP_DIV_CYC,
   parameter [`FDI_CNT_W-1:0] VEC_CYC    = `FDI_VEC_CYC,
   parameter [`FDI_CNT_W-1:0] SWITCH_CYC = `FDI_SWITCH_CYC
) (
   // Clock, reset, enable
   input  wire                 core_clk,
   input  wire                 rst,
   input  wire                 ce,
   // First decoder slot
   input  wire                 fe_valid0,
   input  wire [`FDI_OP_W-1:0] fe_op0,
   input  wire                 fe_rare0,
   input  wire                 fe_straddle0,
   // Second decoder slot
   input  wire                 fe_valid1,
   input  wire [`FDI_OP_W-1:0] fe_op1,
   // Readiness toward the front end
   output reg                  fp_rdy_q,
   output reg                  imul_rdy_q,
   output reg                  gen_rdy_q,
   // Decode and issue events
   output reg                  acc0_q,
   output reg                  pair_q,
   output reg                  vec_q,
   output reg                  switch_q,
   output reg                  state_err_q,
   output reg                  fp_issue_q,
   output reg                  fpu_busy_q,
   output reg                  fpu_done_q,
   output reg                  imul_issue_q,
   output reg                  ld_issue_q,
   output reg                  st_issue_q
);

   function is_fp;
      input [`FDI_OP_W-1:0] op;
      begin
         is_fp = (op >= `FDI_OP_FP_ARITH) && (op <= `FDI_OP_FP_STORE);
      end
   endfunction

   // Memory-operand forms share the register-form count, so no operand flag is needed
   function [`FDI_CNT_W-1:0] fp_cyc;
      input [`FDI_OP_W-1:0] op;
      begin
         case (op)
            `FDI_OP_FP_DIV:   fp_cyc = FP_DIV_CYC;
            `FDI_OP_FP_LOAD:  fp_cyc = `FDI_FP_LDST_CYC;
            `FDI_OP_FP_STORE: fp_cyc = `FDI_FP_LDST_CYC;
            default:          fp_cyc = `FDI_FP_OP_CYC;
         endcase
      end
   endfunction

   function uses_load;
      input [`FDI_OP_W-1:0] op;
      begin
         uses_load = (op == `FDI_OP_INT_LOAD) || (op == `FDI_OP_FP_LOAD);
      end
   endfunction

   function uses_store;
      input [`FDI_OP_W-1:0] op;
      begin
         uses_store = (op == `FDI_OP_INT_STORE) || (op == `FDI_OP_FP_STORE);
      end
   endfunction

   reg [`FDI_ST_W-1:0]  st_q;
   reg [`FDI_ST_W-1:0]  st_d;
   reg [`FDI_CNT_W-1:0] pen_cnt_q;
   reg [`FDI_CNT_W-1:0] pen_cnt_d;
   reg [`FDI_CNT_W-1:0] pend_cyc_q;
   reg [`FDI_CNT_W-1:0] pend_cyc_d;
   reg [`FDI_CNT_W-1:0] fpu_cnt_q;
   reg [`FDI_CNT_W-1:0] fpu_cnt_d;
   reg [`FDI_CNT_W-1:0] imul_cnt_q;
   reg [`FDI_CNT_W-1:0] imul_cnt_d;
   reg                  simd_mode_q;
   reg                  simd_mode_d;
   reg                  clear_pend_q;
   reg                  clear_pend_d;
   reg                  take0;
   reg                  take1;
   reg                  vec0;
   reg                  charge;
   reg                  launch;
   reg                  fp_issue_d;

   // Slot acceptance
   always @*
   begin
      vec0 = fe_rare0 | fe_straddle0;
      if (is_fp(fe_op0))
         take0 = fe_valid0 && fp_rdy_q;
      else if (fe_op0 == `FDI_OP_INT_MUL)
         take0 = fe_valid0 && imul_rdy_q;
      else
         take0 = fe_valid0 && gen_rdy_q;
      // Slot 1 takes only short integer work; an FP op there is left untaken
      take1 = take0 && !vec0 && fe_valid1 && (fe_op1 <= `FDI_OP_INT_STORE)
              && !(uses_load(fe_op1) && uses_load(fe_op0))
              && !(uses_store(fe_op1) && uses_store(fe_op0))
              && !((fe_op1 == `FDI_OP_INT_MUL)
                   && ((fe_op0 == `FDI_OP_INT_MUL) || !imul_rdy_q));
      charge = take0 && is_fp(fe_op0) && (clear_pend_q || simd_mode_q);
      launch = (st_q == `FDI_ST_SWITCH) && (pen_cnt_q == 6'h01) && (pend_cyc_q != 6'h00);
   end

   // Next state
   always @*
   begin
      st_d         = st_q;
      pen_cnt_d    = pen_cnt_q;
      pend_cyc_d   = pend_cyc_q;
      simd_mode_d  = simd_mode_q;
      clear_pend_d = clear_pend_q;
      fp_issue_d   = 1'b0;
      fpu_cnt_d    = (fpu_cnt_q != 6'h00) ? fpu_cnt_q - 6'h01 : 6'h00;
      imul_cnt_d   = (imul_cnt_q != 6'h00) ? imul_cnt_q - 6'h01 : 6'h00;
      case (st_q)
         `FDI_ST_IDLE:
         begin
            if (charge)
            begin
               // Penalty is paid here, never at the clear itself
               st_d       = `FDI_ST_SWITCH;
               pen_cnt_d  = vec0 ? SWITCH_CYC + VEC_CYC : SWITCH_CYC;
               pend_cyc_d = fp_cyc(fe_op0);
            end
            else if (take0 && vec0)
            begin
               st_d      = `FDI_ST_VEC;
               pen_cnt_d = VEC_CYC;
            end
         end
         `FDI_ST_VEC, `FDI_ST_SWITCH:
         begin
            if (pen_cnt_q <= 6'h01)
            begin
               st_d       = `FDI_ST_IDLE;
               pen_cnt_d  = 6'h00;
               pend_cyc_d = 6'h00;
            end
            else
               pen_cnt_d = pen_cnt_q - 6'h01;
         end
         default:
         begin
            st_d      = `FDI_ST_IDLE;
            pen_cnt_d = 6'h00;
         end
      endcase
      if (launch)
      begin
         fpu_cnt_d  = pend_cyc_q;
         fp_issue_d = 1'b1;
      end
      else if (take0 && is_fp(fe_op0) && !charge)
      begin
         fpu_cnt_d  = fp_cyc(fe_op0);
         fp_issue_d = 1'b1;
      end
      // Integer multiplier runs beside the FP unit
      if ((take0 && (fe_op0 == `FDI_OP_INT_MUL)) || (take1 && (fe_op1 == `FDI_OP_INT_MUL)))
         imul_cnt_d = `FDI_INT_MUL_CYC;
      if (take0 && (fe_op0 == `FDI_OP_SIMD))
      begin
         simd_mode_d  = 1'b1;
         clear_pend_d = 1'b0;
      end
      else if (take0 && (fe_op0 == `FDI_OP_SIMD_CLEAR))
         clear_pend_d = 1'b1;
      else if (charge)
      begin
         simd_mode_d  = 1'b0;
         clear_pend_d = 1'b0;
      end
   end

   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         st_q         <= `FDI_ST_IDLE;
         pen_cnt_q    <= 6'h00;
         pend_cyc_q   <= 6'h00;
         fpu_cnt_q    <= 6'h00;
         imul_cnt_q   <= 6'h00;
         simd_mode_q  <= 1'b0;
         clear_pend_q <= 1'b0;
         fp_rdy_q     <= 1'b1;
         imul_rdy_q   <= 1'b1;
         gen_rdy_q    <= 1'b1;
         acc0_q       <= 1'b0;
         pair_q       <= 1'b0;
         vec_q        <= 1'b0;
         switch_q     <= 1'b0;
         state_err_q  <= 1'b0;
         fp_issue_q   <= 1'b0;
         fpu_busy_q   <= 1'b0;
         fpu_done_q   <= 1'b0;
         imul_issue_q <= 1'b0;
         ld_issue_q   <= 1'b0;
         st_issue_q   <= 1'b0;
      end
      else if (ce)
      begin
         st_q         <= st_d;
         pen_cnt_q    <= pen_cnt_d;
         pend_cyc_q   <= pend_cyc_d;
         fpu_cnt_q    <= fpu_cnt_d;
         imul_cnt_q   <= imul_cnt_d;
         simd_mode_q  <= simd_mode_d;
         clear_pend_q <= clear_pend_d;
         // Readiness looks one cycle ahead so the ports come straight from flops
         fp_rdy_q     <= (st_d == `FDI_ST_IDLE) && (fpu_cnt_d == 6'h00);
         imul_rdy_q   <= (st_d == `FDI_ST_IDLE) && (imul_cnt_d == 6'h00);
         gen_rdy_q    <= (st_d == `FDI_ST_IDLE);
         acc0_q       <= take0;
         pair_q       <= take1;
         vec_q        <= take0 && vec0;
         switch_q     <= charge;
         // FP use straight after SIMD code without a clear is flagged but still served
         state_err_q  <= charge && !clear_pend_q;
         fp_issue_q   <= fp_issue_d;
         fpu_busy_q   <= (fpu_cnt_d != 6'h00);
         fpu_done_q   <= (fpu_cnt_q == 6'h01);
         imul_issue_q <= (imul_cnt_d == `FDI_INT_MUL_CYC) && (imul_cnt_q != `FDI_INT_MUL_CYC);
         ld_issue_q   <= (take0 && uses_load(fe_op0)) || (take1 && uses_load(fe_op1));
         st_issue_q   <= (take0 && uses_store(fe_op0)) || (take1 && uses_store(fe_op1));
      end
   end

endmodule // fdi_timing

// ==== hdl/fdi_timing_regs.vh ====
// Constants for the floating-point decode and issue timing block
`ifndef FDI_TIMING_REGS_VH
`define FDI_TIMING_REGS_VH

// Operation classes presented by the front end
`define FDI_OP_W          4
`define FDI_OP_INT_ALU    4'h0
`define FDI_OP_INT_MUL    4'h1
`define FDI_OP_INT_LOAD   4'h2
`define FDI_OP_INT_STORE  4'h3
`define FDI_OP_FP_ARITH   4'h4
`define FDI_OP_FP_MUL     4'h5
`define FDI_OP_FP_DIV     4'h6
`define FDI_OP_FP_LOAD    4'h7
`define FDI_OP_FP_STORE   4'h8
`define FDI_OP_SIMD       4'h9
`define FDI_OP_SIMD_CLEAR 4'hA

// Counter width and cycle counts
`define FDI_CNT_W         6
`define FDI_FP_OP_CYC     6'h02
`define FDI_FP_LDST_CYC   6'h02
`define FDI_FP_DIV_CYC    6'h10
`define FDI_INT_MUL_CYC   6'h02
`define FDI_VEC_CYC       6'h02
`define FDI_SWITCH_CYC    6'h02

// Decoder states
`define FDI_ST_W          2
`define FDI_ST_IDLE       2'h0
`define FDI_ST_VEC        2'h1
`define FDI_ST_SWITCH     2'h2

`endif

// ==== verification/fdi_timing_asserts.sv ====
// Checker for the FP decode and issue timing block
`timescale 1ns/100ps
module fdi_timing_asserts #(
   parameter [5:0] FP_DIV_CYC = 6'h10
) (
   // Clock and reset
   input wire       core_clk,
   input wire       rst,
   // Slot inputs
   input wire       fe_rare0,
   input wire       fe_straddle0,
   input wire [3:0] fe_op1,
   // Outputs watched
   input wire       fp_rdy_q,
   input wire       imul_rdy_q,
   input wire       gen_rdy_q,
   input wire       acc0_q,
   input wire       pair_q,
   input wire       vec_q,
   input wire       switch_q,
   input wire       fp_issue_q,
   input wire       fpu_busy_q,
   input wire       fpu_done_q
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // Busy length; a plain delay cannot follow a parameterised divide count
   reg [5:0] busy_cnt_q;
   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
         busy_cnt_q <= 6'h00;
      else
         busy_cnt_q <= fpu_busy_q ? busy_cnt_q + 6'h01 : 6'h00;
   end
   chk_fp_nopipe: assert property (fp_issue_q |=> !fp_issue_q)
      else $error("fp issue on consecutive cycles");
   chk_rdy_busy: assert property (fpu_busy_q |-> !fp_rdy_q)
      else $error("fp ready while unit busy");
   chk_issue_busy: assert property (fp_issue_q |-> fpu_busy_q)
      else $error("issue without busy");
   chk_done_release: assert property (fpu_done_q |-> fp_rdy_q == gen_rdy_q && !fpu_busy_q)
      else $error("ready not back at done");
   chk_busy_len: assert property (fpu_done_q |-> busy_cnt_q == 6'h02
      || busy_cnt_q == FP_DIV_CYC) else $error("wrong fp unit occupancy");
   chk_pair_first: assert property (pair_q |-> acc0_q && !vec_q
      && $past(fe_op1) <= 4'h3) else $error("bad pairing");
   chk_vec_cause: assert property (vec_q |-> $past(fe_rare0 || fe_straddle0))
      else $error("vector path without cause");
   chk_switch_hold: assert property (switch_q |-> !fp_rdy_q && !gen_rdy_q && !imul_rdy_q)
      else $error("ready during switch");
   chk_switch_late: assert property (switch_q |-> !fp_issue_q ##1 !fp_issue_q ##[1:3] fp_issue_q)
      else $error("switch penalty length");
endmodule // fdi_timing_asserts
bind fdi_timing fdi_timing_asserts #(.FP_DIV_CYC(FP_DIV_CYC)) u_chk (.core_clk(core_clk),
   .rst(rst), .fe_rare0(fe_rare0), .fe_straddle0(fe_straddle0), .fe_op1(fe_op1),
   .fp_rdy_q(fp_rdy_q), .imul_rdy_q(imul_rdy_q), .gen_rdy_q(gen_rdy_q), .acc0_q(acc0_q),
   .pair_q(pair_q), .vec_q(vec_q), .switch_q(switch_q), .fp_issue_q(fp_issue_q),
   .fpu_busy_q(fpu_busy_q), .fpu_done_q(fpu_done_q));

// ==== verification/fdi_fe_model.sv ====
// Front-end model presenting ops to the two decoder slots
`timescale 1ns/100ps
`include "fdi_timing_regs.vh"
module fdi_fe_model (
   // Clock
   input  wire                 core_clk,
   // Readiness from the block
   input  wire                 fp_rdy_q,
   input  wire                 imul_rdy_q,
   input  wire                 gen_rdy_q,
   // Slots
   output reg                  fe_valid0,
   output reg  [`FDI_OP_W-1:0] fe_op0,
   output reg                  fe_rare0,
   output reg                  fe_straddle0,
   output reg                  fe_valid1,
   output reg  [`FDI_OP_W-1:0] fe_op1
);
   initial
   begin
      {fe_valid0, fe_op0, fe_rare0, fe_straddle0, fe_valid1, fe_op1} = 11'h000;
   end
   // No refusal signal exists, so a request is held until the ready of its class
   task send(input [3:0] op, input rare, input strad, input v1, input [3:0] op1, output ok);
      integer n;
      begin
         @(negedge core_clk);
         {fe_valid0, fe_op0, fe_rare0, fe_straddle0, fe_valid1, fe_op1} = {1'b1, op, rare, strad, v1, op1};
         n = 0;
         while (((op >= 4'h4 && op <= 4'h8) ? fp_rdy_q : (op == 4'h1 ? imul_rdy_q : gen_rdy_q))
                !== 1'b1 && n < 64)
         begin
            @(negedge core_clk);
            n = n + 1;
         end
         ok = n < 64;
         @(negedge core_clk);
         // Released slots drop both valids and show inverted op and flag values so stale ones never pass for live
         {fe_valid0, fe_op0, fe_rare0, fe_straddle0, fe_valid1, fe_op1} = {1'b0, ~op, ~rare, ~strad, 1'b0, ~op1};
      end
   endtask
endmodule // fdi_fe_model

// ==== verification/fdi_timing_tb.sv ====
// Self-checking bench for the FP decode and issue timing block
`timescale 1ns/100ps
`include "fdi_timing_regs.vh"
module fdi_timing_tb;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   wire v0, ra0, st0, v1, frdy, irdy, grdy, acc0, pair, vec, sw, serr, iss, busy, done, imi, ldi, sti;
   wire [3:0] op0, op1;
   integer failures = 0;
   integer compares = 0;
   integer n;
   time t0;
   fdi_fe_model fe (.core_clk(core_clk), .fp_rdy_q(frdy), .imul_rdy_q(irdy), .gen_rdy_q(grdy),
      .fe_valid0(v0), .fe_op0(op0), .fe_rare0(ra0), .fe_straddle0(st0), .fe_valid1(v1), .fe_op1(op1));
   fdi_timing uut (.core_clk(core_clk), .rst(rst), .ce(1'b1), .fe_valid0(v0), .fe_op0(op0),
      .fe_rare0(ra0), .fe_straddle0(st0), .fe_valid1(v1), .fe_op1(op1), .fp_rdy_q(frdy),
      .imul_rdy_q(irdy), .gen_rdy_q(grdy), .acc0_q(acc0), .pair_q(pair), .vec_q(vec),
      .switch_q(sw), .state_err_q(serr), .fp_issue_q(iss), .fpu_busy_q(busy), .fpu_done_q(done),
      .imul_issue_q(imi), .ld_issue_q(ldi), .st_issue_q(sti));
   initial
   begin
      forever #25 core_clk = ~core_clk;
   end
   task conclude;
      begin
         $display("compares %0d failures %0d", compares, failures);
         if (failures == 0 && compares > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   task chk(input [8*10-1:0] nm, input [5:0] seen, input [5:0] exp);
      begin
         compares = compares + 1;
         if (seen !== exp)
         begin
            failures = failures + 1;
            $display("FAIL %0s exp %0h seen %0h", nm, exp, seen);
         end
      end
   endtask
   task s(input [3:0] op, input ra, input st, input sv1, input [3:0] sop1);
      logic ok;
      begin
         fe.send(op, ra, st, sv1, sop1, ok);
         if (!ok)
         begin
            failures = failures + 1;
            conclude;
         end
      end
   endtask
   // Counts falling edges until the unit reports done
   task wd;
      begin
         n = 0;
         while (done !== 1'b1 && n < 40)
         begin
            @(negedge core_clk);
            n = n + 1;
         end
         if (done !== 1'b1)
         begin
            failures = failures + 1;
            conclude;
         end
      end
   endtask
   task t_pair;
      begin
         s(`FDI_OP_FP_MUL, 1'b0, 1'b0, 1'b1, `FDI_OP_INT_MUL);
         chk("pair", {4'h0, acc0, pair}, 6'h03);
         chk("imul_par", {4'h0, imi, iss}, 6'h03);
         wd;
         // Issue to done spans the whole unit occupancy
         chk("mul_lat", n[5:0], `FDI_FP_OP_CYC);
         s(`FDI_OP_INT_LOAD, 1'b0, 1'b0, 1'b1, `FDI_OP_INT_STORE);
         chk("ld_st", {4'h0, ldi, sti}, 6'h03);
         s(`FDI_OP_INT_ALU, 1'b0, 1'b0, 1'b1, `FDI_OP_FP_ARITH);
         chk("slot1_fp", {5'h00, pair}, 6'h00);
         $display("test pair done");
      end
   endtask
   task t_vec;
      integer i;
      begin
         for (i = 0; i < 3; i = i + 1)
         begin
            s(`FDI_OP_FP_ARITH, i == 1, i == 2, 1'b0, 4'h0);
            chk("vec", {5'h00, vec}, {5'h00, i != 0});
            wd;
         end
         $display("test vector done");
      end
   endtask
   task t_switch;
      begin
         s(`FDI_OP_SIMD_CLEAR, 1'b0, 1'b0, 1'b0, 4'h0);
         chk("clr_sw", {5'h00, sw}, 6'h00);
         s(`FDI_OP_FP_ARITH, 1'b0, 1'b0, 1'b0, 4'h0);
         chk("fp_sw", {3'h0, serr, sw, iss}, 6'h02);
         wd;
         s(`FDI_OP_SIMD, 1'b0, 1'b0, 1'b0, 4'h0);
         s(`FDI_OP_FP_ARITH, 1'b0, 1'b0, 1'b0, 4'h0);
         chk("state_err", {5'h00, serr}, 6'h01);
         wd;
         $display("test switch done");
      end
   endtask
   task t_lat;
      begin
         s(`FDI_OP_FP_DIV, 1'b0, 1'b0, 1'b0, 4'h0);
         wd;
         chk("div_lat", n[5:0], `FDI_FP_DIV_CYC);
         s(`FDI_OP_FP_LOAD, 1'b0, 1'b0, 1'b0, 4'h0);
         t0 = $time;
         s(`FDI_OP_FP_STORE, 1'b0, 1'b0, 1'b0, 4'h0);
         wd;
         // One release cycle separates the two unit occupancies
         t0 = ($time - t0) / 50;
         chk("ld_st_fp", t0[5:0], `FDI_FP_LDST_CYC + `FDI_FP_LDST_CYC + 6'h01);
         $display("test latency done");
      end
   endtask
   initial
   begin
      repeat (16) @(negedge core_clk);
      rst = 1'b0;
      t_pair;
      t_vec;
      t_switch;
      t_lat;
      conclude;
   end
endmodule // fdi_timing_tb
